// file: debug_shifter.sv
// Purpose: Serial load and capture shift register
// Assumes: Inputs already synchronised
// Notes: Shifts MSB first every cycle unless held or capturing
`include "stack_cpu_cfg.svh"

module debug_shifter
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_hold,
   input wire logic i_capture,
   input wire logic i_serial,
   input wire logic [7:0] i_capture_val,
   output logic [7:0] o_value,
   output logic o_serial
);

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         o_value <= `MEM_RESET;
      else if (i_capture)
         o_value <= i_capture_val;
      else if (!i_hold)
         o_value <= {o_value[6:0], i_serial};
   end

   assign o_serial = o_value[7];

endmodule // debug_shifter

// file: host_serial_model.sv
// Purpose: Host side of the serial load and capture interface
// Assumes: Pins change just after a rising clock edge
// Notes: Tasks are called from the bench; one access at a time
module host_serial_model
(
   input wire logic i_core_clk,
   input wire logic i_serial,
   output stack_cpu_pkg::ctl_pins_t o_pins
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_pins = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // Shift eight bits in MSB first, then hold load for one cycle
   task automatic write_reg(input logic [1:0] sel, input logic [7:0] val);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge i_core_clk);
         o_pins.shift_in <= val[i];
      end
      @(posedge i_core_clk);
      o_pins.reg_sel <= sel;
      o_pins.load <= 1'b1;
      @(posedge i_core_clk);
      o_pins.load <= 1'b0;
      repeat (4) @(posedge i_core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Capture for one cycle, then collect eight bits MSB first
   task automatic read_reg(input logic [1:0] sel, output logic [7:0] val);
      @(posedge i_core_clk);
      o_pins.reg_sel <= sel;
      o_pins.dump <= 1'b1;
      @(posedge i_core_clk);
      o_pins.dump <= 1'b0;
      @(posedge i_core_clk);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge i_core_clk);
         #1 val[i] = i_serial;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Run pin pulse
   task automatic pulse_run;
      @(posedge i_core_clk);
      o_pins.run <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_pins.run <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Step pin pulse
   task automatic pulse_step;
      @(posedge i_core_clk);
      o_pins.step <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_pins.step <= 1'b0;
   endtask
endmodule // host_serial_model

// file: stack_cpu_cfg.svh
// Purpose: Constants for the stack language processor
// Assumes: 200 MHz core clock
// Notes: Offsets, reset values, opcodes and timing counts
`ifndef STACK_CPU_CFG_SVH
`define STACK_CPU_CFG_SVH

// Serial register select codes
`define REG_PC 2'h0
`define REG_SP 2'h1
`define REG_EXECUTE_IN_PLACE 2'h2
`define REG_STACK 2'h3

// Reset values
`define PROG_RESET 8'hff
`define MEM_RESET 8'h00
`define PTR_RESET 8'h00

// Data space map
`define DATA_LIMIT 8'h20
`define IO_PINB 8'h36
`define IO_DDRB 8'h37
`define IO_PORTB 8'h38
`define IO_PINA 8'h39
`define IO_AUX_OE 8'h3a
`define IO_PORTA 8'h3b

// Opcodes
`define OP_DELAY 8'h2c
`define OP_SHR 8'h3e
`define OP_SHL 8'h3c
`define OP_JUMP 8'h3d
`define OP_LOOP 8'h40
`define OP_AND 8'h26
`define OP_OR 8'h7c
`define OP_XOR 8'h5e
`define OP_ADD 8'h2b
`define OP_SUB 8'h2d
`define OP_DUP 8'h32
`define OP_RDPROG 8'h3f
`define OP_WRPROG 8'h21
`define OP_RDDATA 8'h72
`define OP_WRDATA 8'h77
`define OP_SLEEP 8'h7a
`define OP_STOP 8'hff

// Timing
`define CLK_PERIOD_NS 5
`define DELAY_UNIT_NS 1000000

`endif

// file: stack_cpu_pkg.sv
// Purpose: Types for the stack language processor
// Assumes: Constants come from the cfg header
// Notes: Nothing here is imported; use scoped names
package stack_cpu_pkg;

   typedef enum logic [2:0]
   {
      st_idle = 3'b000,
      st_execute_in_place = 3'b001,
      st_delay = 3'b011,
      st_sleep = 3'b010,
      st_stop = 3'b110
   } cpu_state_t;

   typedef struct packed
   {
      logic run;
      logic step;
      logic load;
      logic dump;
      logic shift_in;
      logic [1:0] reg_sel;
   } ctl_pins_t;

endpackage

// file: stack_language_cpu.sv
// Purpose: Stack language processor with serial debug access
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes: One clock; pins pass two flip-flops before use
// Function
// - 256-byte writable program memory holds fetched instructions.
// - 32-byte operand stack addressed by the stack pointer.
// - Separate 32-byte data memory.
// - Eight bidirectional pins plus eight output-only pins.
// - Reset fills program memory with all ones.
// - Reset clears stack and data memory.
// - Reset clears program counter and stack pointer.
// - Fetch byte at program counter, execute it, advance counter.
// - Select 0 counter, 1 stack pointer, 2 execute port, 3 stack port.
// - Stack port read gives top of stack; write pushes.
// - All serial access goes through one shift register.
// - Load high copies shift register into selected register.
// - Capture high copies register out; MSB on serial output next.
// - Execute port runs opcode without moving counter unless jumping.
// - Aux bits with enable zero show sleep, halt, delay, serial, zeros.
`include "stack_cpu_cfg.svh"

module stack_language_cpu
#(
   parameter int DELAY_TICK_CYCLES = `DELAY_UNIT_NS / `CLK_PERIOD_NS
)
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_run,
   input wire logic i_step,
   input wire logic i_load,
   input wire logic i_dump,
   input wire logic i_shift_in,
   input wire logic [1:0] i_reg_sel,
   input wire logic [7:0] i_portb,
   output logic [7:0] o_portb,
   output logic [7:0] o_portb_oe_n,
   output logic [7:0] o_porta
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edges
   stack_cpu_pkg::ctl_pins_t pin_meta_r;
   stack_cpu_pkg::ctl_pins_t pin_r;
   logic [7:0] pb_meta_r;
   logic [7:0] pb_r;
   logic load_prev_r;
   logic run_prev_r;
   logic step_prev_r;

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         pin_meta_r <= '0;
         pin_r <= '0;
         pb_meta_r <= '0;
         pb_r <= '0;
         load_prev_r <= 1'b0;
         run_prev_r <= 1'b0;
         step_prev_r <= 1'b0;
      end
      else
      begin
         pin_meta_r <= {i_run, i_step, i_load, i_dump, i_shift_in, i_reg_sel};
         pin_r <= pin_meta_r;
         pb_meta_r <= i_portb;
         pb_r <= pb_meta_r;
         load_prev_r <= pin_r.load;
         run_prev_r <= pin_r.run;
         step_prev_r <= pin_r.step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State and storage
   stack_cpu_pkg::cpu_state_t state_r;
   logic [7:0] prog_r [256];
   logic [7:0] stk_r [32];
   logic [7:0] dmem_r [32];
   logic [7:0] pc_r;
   logic [7:0] sp_r;
   logic [7:0] ddrb_r;
   logic [7:0] portb_r;
   logic [7:0] aux_oe_r;
   logic [7:0] porta_r;
   logic [7:0] delay_cnt_r;
   logic [31:0] tick_cnt_r;
   logic [7:0] sreg;
   logic serial_out;
   logic [7:0] cap_val;
   logic [4:0] i1;
   logic [4:0] i2;
   logic [7:0] top;
   logic [7:0] nxt;
   logic [7:0] op;
   logic [7:0] rd;
   logic load_rise;
   logic run_rise;
   logic step_go;
   logic execute_in_place_go;
   logic push_go;
   logic run_go;
   logic do_op;
   logic tick;

   assign i1 = sp_r[4:0] - 5'd1;
   assign i2 = sp_r[4:0] - 5'd2;
   assign top = stk_r[i1];
   assign nxt = stk_r[i2];
   assign load_rise = pin_r.load & ~load_prev_r;
   assign run_rise = pin_r.run & ~run_prev_r;
   assign step_go = pin_r.step & ~step_prev_r & (state_r != stack_cpu_pkg::st_execute_in_place)
      & (state_r != stack_cpu_pkg::st_delay);
   assign execute_in_place_go = load_rise & (pin_r.reg_sel == `REG_EXECUTE_IN_PLACE);
   assign push_go = load_rise & (pin_r.reg_sel == `REG_STACK);
   assign run_go = ((state_r == stack_cpu_pkg::st_execute_in_place) | step_go) & ~pin_r.load;
   assign do_op = execute_in_place_go | run_go;
   assign op = execute_in_place_go ? sreg : prog_r[pc_r];
   assign tick = (tick_cnt_r == 32'(DELAY_TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////////
   // Serial register access
   always_comb
   begin
      case (pin_r.reg_sel)
         `REG_PC: cap_val = pc_r;
         `REG_SP: cap_val = sp_r;
         `REG_STACK: cap_val = top;
         default: cap_val = 8'h00;
      endcase
   end

   debug_shifter u_shifter
   (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_hold(pin_r.load),
      .i_capture(pin_r.dump),
      .i_serial(pin_r.shift_in),
      .i_capture_val(cap_val),
      .o_value(sreg),
      .o_serial(serial_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Opcode decoder
   logic [7:0] pc_nxt;
   logic [7:0] sp_nxt;
   logic s_we;
   logic [4:0] s_wi;
   logic [7:0] s_wd;
   logic p_we;
   logic d_we;
   logic delay_go;
   logic sleep_go;
   logic stop_go;

   always_comb
   begin
      case (top)
         `IO_PINB: rd = pb_r;
         `IO_DDRB: rd = ddrb_r;
         `IO_PORTB: rd = portb_r;
         `IO_AUX_OE: rd = aux_oe_r;
         `IO_PORTA: rd = porta_r;
         default: rd = (top < `DATA_LIMIT) ? dmem_r[top[4:0]] : 8'h00;
      endcase
   end

   always_comb
   begin
      pc_nxt = execute_in_place_go ? pc_r : pc_r + 8'h01;
      sp_nxt = sp_r;
      s_we = 1'b1;
      s_wi = i1;
      s_wd = top;
      p_we = 1'b0;
      d_we = 1'b0;
      delay_go = 1'b0;
      sleep_go = 1'b0;
      stop_go = 1'b0;
      case (op)
         `OP_DELAY:
         begin
            s_we = 1'b0;
            delay_go = 1'b1;
            sp_nxt = sp_r - 8'h01;
         end
         `OP_SHR: s_wd = top >> 1;
         `OP_SHL: s_wd = top << 1;
         `OP_JUMP:
         begin
            s_we = 1'b0;
            pc_nxt = top;
            sp_nxt = sp_r - 8'h01;
         end
         `OP_LOOP:
         begin
            s_wi = i2;
            s_wd = nxt - 8'h01;
            s_we = (nxt != 8'h00);
            pc_nxt = (nxt != 8'h00) ? top : pc_nxt;
            sp_nxt = (nxt != 8'h00) ? sp_r - 8'h01 : sp_r - 8'h02;
         end
         `OP_AND, `OP_OR, `OP_XOR, `OP_ADD, `OP_SUB:
         begin
            s_wi = i2;
            sp_nxt = sp_r - 8'h01;
            case (op)
               `OP_AND: s_wd = nxt & top;
               `OP_OR: s_wd = nxt | top;
               `OP_XOR: s_wd = nxt ^ top;
               `OP_ADD: s_wd = nxt + top;
               default: s_wd = nxt - top;
            endcase
         end
         `OP_DUP:
         begin
            s_wi = sp_r[4:0];
            sp_nxt = sp_r + 8'h01;
         end
         `OP_RDPROG: s_wd = prog_r[top];
         `OP_WRPROG:
         begin
            s_we = 1'b0;
            p_we = 1'b1;
            sp_nxt = sp_r - 8'h02;
         end
         `OP_RDDATA: s_wd = rd;
         `OP_WRDATA:
         begin
            s_we = 1'b0;
            d_we = 1'b1;
            sp_nxt = sp_r - 8'h02;
         end
         `OP_SLEEP:
         begin
            s_we = 1'b0;
            sleep_go = 1'b1;
         end
         `OP_STOP:
         begin
            s_we = 1'b0;
            stop_go = 1'b1;
            pc_nxt = pc_r;
         end
         default:
         begin
            s_wi = sp_r[4:0];
            s_wd = op;
            sp_nxt = sp_r + 8'h01;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         state_r <= stack_cpu_pkg::st_idle;
      else
      begin
         case (state_r)
            stack_cpu_pkg::st_execute_in_place:
            begin
               if (run_go && delay_go)
                  state_r <= stack_cpu_pkg::st_delay;
               else if (run_go && sleep_go)
                  state_r <= stack_cpu_pkg::st_sleep;
               else if (run_go && stop_go)
                  state_r <= stack_cpu_pkg::st_stop;
            end
            stack_cpu_pkg::st_delay:
            begin
               if (delay_cnt_r == 8'h00 || (tick && delay_cnt_r == 8'h01))
                  state_r <= stack_cpu_pkg::st_execute_in_place;
            end
            stack_cpu_pkg::st_idle, stack_cpu_pkg::st_sleep, stack_cpu_pkg::st_stop:
            begin
               if (run_rise)
                  state_r <= stack_cpu_pkg::st_execute_in_place;
            end
            default: state_r <= stack_cpu_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset || state_r != stack_cpu_pkg::st_delay || tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + 32'd1;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         delay_cnt_r <= `MEM_RESET;
      else if (run_go && delay_go)
         delay_cnt_r <= top;
      else if (tick && delay_cnt_r != 8'h00)
         delay_cnt_r <= delay_cnt_r - 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pointers
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         pc_r <= `PTR_RESET;
      else if (pin_r.load && pin_r.reg_sel == `REG_PC)
         pc_r <= sreg;
      else if (do_op)
         pc_r <= pc_nxt;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         sp_r <= `PTR_RESET;
      else if (pin_r.load && pin_r.reg_sel == `REG_SP)
         sp_r <= sreg;
      else if (push_go)
         sp_r <= sp_r + 8'h01;
      else if (do_op)
         sp_r <= sp_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memories
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         for (int k = 0; k < 256; k++)
            prog_r[k] <= `PROG_RESET;
      end
      else if (do_op && p_we)
         prog_r[top] <= nxt;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         for (int k = 0; k < 32; k++)
            stk_r[k] <= `MEM_RESET;
      end
      else if (push_go)
         stk_r[sp_r[4:0]] <= sreg;
      else if (do_op && s_we)
         stk_r[s_wi] <= s_wd;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         for (int k = 0; k < 32; k++)
            dmem_r[k] <= `MEM_RESET;
      end
      else if (do_op && d_we && top < `DATA_LIMIT)
         dmem_r[top[4:0]] <= nxt;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         ddrb_r <= `MEM_RESET;
         portb_r <= `MEM_RESET;
         aux_oe_r <= `MEM_RESET;
         porta_r <= `MEM_RESET;
      end
      else if (do_op && d_we)
      begin
         case (top)
            `IO_PINB: portb_r <= portb_r ^ nxt;
            `IO_DDRB: ddrb_r <= nxt;
            `IO_PORTB: portb_r <= nxt;
            `IO_PINA: porta_r <= porta_r ^ nxt;
            `IO_AUX_OE: aux_oe_r <= nxt;
            `IO_PORTA: porta_r <= nxt;
            default: porta_r <= porta_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins
   logic [7:0] dbg;

   assign dbg = {4'h0, serial_out, state_r == stack_cpu_pkg::st_delay,
      state_r == stack_cpu_pkg::st_stop, state_r == stack_cpu_pkg::st_sleep};
   assign o_porta = (aux_oe_r & porta_r) | (~aux_oe_r & dbg);
   assign o_portb = portb_r;
   assign o_portb_oe_n = ~ddrb_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   chk_reset_ptrs: assert property ($fell(i_reset) |-> pc_r == 8'h00 && sp_r == 8'h00)
      else $error("pointers not cleared by reset");
   chk_reset_mems: assert property ($fell(i_reset) |-> prog_r[8'h80] == 8'hff
      && stk_r[0] == 8'h00 && dmem_r[31] == 8'h00)
      else $error("memories not initialised by reset");
   chk_fetch_advance: assert property (run_go && !execute_in_place_go && op == 8'h05
      |=> pc_r == $past(pc_r) + 8'h01)
      else $error("program counter did not advance");
   chk_literal_push: assert property (do_op && op == 8'h05
      |=> sp_r == $past(sp_r) + 8'h01 ##0 stk_r[$past(sp_r[4:0])] == 8'h05)
      else $error("literal not pushed");
   chk_stack_push: assert property (push_go
      |=> stk_r[$past(sp_r[4:0])] == $past(sreg) && sp_r == $past(sp_r) + 8'h01)
      else $error("stack port write did not push");
   chk_load_pc: assert property (pin_r.load && pin_r.reg_sel == 2'h0
      |=> pc_r == $past(sreg))
      else $error("program counter not loaded");
   chk_capture_out: assert property (pin_r.dump
      |=> sreg == $past(cap_val) && serial_out == sreg[7])
      else $error("capture did not reach serial output");
   chk_execute_in_place_keeps_pc: assert property (execute_in_place_go && sreg != 8'h3d && sreg != 8'h40
      && sreg != 8'hff |=> pc_r == $past(pc_r))
      else $error("execute port moved program counter");
   chk_aux_debug: assert property (aux_oe_r[7:3] == 5'h00
      |-> o_porta[7:4] == 4'h0 && o_porta[3] == serial_out)
      else $error("aux debug output wrong");

endmodule // stack_language_cpu

// file: stack_language_cpu_test.sv
// Purpose: Self-checking bench for the stack language processor
// Assumes: Host model drives the serial pins
// Notes: A queue models the operand stack
`include "stack_cpu_cfg.svh"

module stack_language_cpu_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] i_portb = 8'h00;
   logic [7:0] o_portb;
   logic [7:0] o_portb_oe_n;
   logic [7:0] o_porta;
   stack_cpu_pkg::ctl_pins_t pins;
   int err_count = 0;
   int checks_done = 0;
   int cnt;
   int stk[$];
   logic [7:0] got;
   logic [7:0] a;
   logic [7:0] b;
   logic [7:0] r;
   logic [7:0] ops[5] = '{`OP_AND, `OP_OR, `OP_XOR, `OP_ADD, `OP_SUB};
   logic [7:0] prog[4] = '{8'h05, 8'h07, `OP_ADD, `OP_STOP};
   logic [7:0] prog2[4] = '{8'h03, `OP_DELAY, `OP_SLEEP, 8'h42};
   localparam int TICKS = 4;

   always #2.5 i_core_clk = ~i_core_clk;

   stack_language_cpu #(.DELAY_TICK_CYCLES(TICKS)) i_stack_language_cpu
   (
      .i_core_clk(i_core_clk), .i_reset(i_reset), .i_run(pins.run), .i_step(pins.step),
      .i_load(pins.load), .i_dump(pins.dump), .i_shift_in(pins.shift_in),
      .i_reg_sel(pins.reg_sel), .i_portb(i_portb), .o_portb(o_portb),
      .o_portb_oe_n(o_portb_oe_n), .o_porta(o_porta)
   );

   host_serial_model i_host_serial_model
   (
      .i_core_clk(i_core_clk), .i_serial(o_porta[3]), .o_pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
      checks_done++;
      if (got_v !== exp_v)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask

   task automatic rd_check(input logic [1:0] sel, input logic [7:0] exp_v);
      i_host_serial_model.read_reg(sel, got);
      check(got, exp_v);
   endtask

   task automatic push(input logic [7:0] v);
      i_host_serial_model.write_reg(`REG_STACK, v);
      stk.push_back(v);
   endtask

   task automatic execute_in_place_op(input logic [7:0] op);
      i_host_serial_model.write_reg(`REG_EXECUTE_IN_PLACE, op);
   endtask

   task automatic data_write(input logic [7:0] v, input logic [7:0] addr);
      push(v);
      push(addr);
      execute_in_place_op(`OP_WRDATA);
      void'(stk.pop_back());
      void'(stk.pop_back());
   endtask

   task automatic prog_write(input logic [7:0] v, input logic [7:0] addr);
      push(v);
      push(addr);
      execute_in_place_op(`OP_WRPROG);
      void'(stk.pop_back());
      void'(stk.pop_back());
   endtask

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Tests
   initial
   begin
      void'($urandom(21248));
      repeat (5) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd_check(`REG_PC, `PTR_RESET);
      rd_check(`REG_SP, `PTR_RESET);
      rd_check(`REG_EXECUTE_IN_PLACE, 8'h00);
      check(o_portb_oe_n, 8'hff);
      check(o_porta, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         a = 8'($urandom);
         i_host_serial_model.write_reg(`REG_SP, a);
         rd_check(`REG_SP, a);
         i_host_serial_model.write_reg(`REG_SP, 8'h00);
         a = 8'($urandom);
         i_host_serial_model.write_reg(`REG_PC, a);
         rd_check(`REG_PC, a);
      end
      $display("test pointers done");
      for (int i = 0; i < 3; i++)
      begin
         push(8'($urandom));
         rd_check(`REG_STACK, 8'(stk[$]));
         rd_check(`REG_SP, 8'(stk.size()));
      end
      $display("test stack done");
      push(8'h80);
      execute_in_place_op(`OP_RDPROG);
      rd_check(`REG_STACK, `PROG_RESET);
      rd_check(`REG_PC, a);
      push(8'h1f);
      execute_in_place_op(`OP_RDDATA);
      rd_check(`REG_STACK, `MEM_RESET);
      b = 8'($urandom);
      data_write(b, 8'h03);
      push(8'h03);
      execute_in_place_op(`OP_RDDATA);
      stk[$] = b;
      rd_check(`REG_STACK, b);
      $display("test memories done");
      foreach (ops[k])
      begin
         a = 8'($urandom);
         b = 8'($urandom);
         push(a);
         push(b);
         execute_in_place_op(ops[k]);
         case (k)
            0: r = a & b;
            1: r = a | b;
            2: r = a ^ b;
            3: r = a + b;
            default: r = a - b;
         endcase
         void'(stk.pop_back());
         stk[$] = r;
         rd_check(`REG_STACK, r);
         rd_check(`REG_SP, 8'(stk.size()));
      end
      push(8'h40);
      execute_in_place_op(`OP_JUMP);
      void'(stk.pop_back());
      rd_check(`REG_PC, 8'h40);
      a = 8'($urandom);
      push(a);
      execute_in_place_op(`OP_SHR);
      stk[$] = a >> 1;
      rd_check(`REG_STACK, 8'(stk[$]));
      execute_in_place_op(`OP_SHL);
      stk[$] = 8'(stk[$] << 1);
      rd_check(`REG_STACK, 8'(stk[$]));
      execute_in_place_op(`OP_DUP);
      stk.push_back(stk[$]);
      rd_check(`REG_SP, 8'(stk.size()));
      rd_check(`REG_STACK, 8'(stk[$]));
      push(8'h02);
      push(8'h50);
      execute_in_place_op(`OP_LOOP);
      void'(stk.pop_back());
      stk[$] = 8'h01;
      rd_check(`REG_PC, 8'h50);
      rd_check(`REG_STACK, 8'h01);
      push(8'h60);
      execute_in_place_op(`OP_LOOP);
      void'(stk.pop_back());
      stk[$] = 8'h00;
      push(8'h70);
      execute_in_place_op(`OP_LOOP);
      void'(stk.pop_back());
      void'(stk.pop_back());
      rd_check(`REG_PC, 8'h60);
      rd_check(`REG_SP, 8'(stk.size()));
      $display("test execute done");
      a = 8'($urandom);
      data_write(a, `IO_PORTB);
      data_write(8'hff, `IO_DDRB);
      check(o_portb, a);
      check(o_portb_oe_n, 8'h00);
      b = 8'($urandom);
      i_portb <= b;
      push(`IO_PINB);
      execute_in_place_op(`OP_RDDATA);
      stk[$] = b;
      rd_check(`REG_STACK, b);
      a = 8'($urandom);
      data_write(a, `IO_PORTA);
      data_write(8'hff, `IO_AUX_OE);
      check(o_porta, a);
      data_write(8'h00, `IO_AUX_OE);
      check(o_porta & 8'hf0, 8'h00);
      $display("test ports done");
      foreach (prog[k])
         prog_write(prog[k], 8'(8'h10 + k));
      i_host_serial_model.write_reg(`REG_PC, 8'h10);
      i_host_serial_model.pulse_run();
      for (int n = 0; n < 200 && o_porta[1] !== 1'b1; n++)
         @(posedge i_core_clk);
      check(8'(o_porta[1]), 8'h01);
      stk.push_back(8'h05 + 8'h07);
      rd_check(`REG_STACK, 8'h0c);
      rd_check(`REG_SP, 8'(stk.size()));
      rd_check(`REG_PC, 8'h13);
      $display("test program done");
      foreach (prog2[k])
         prog_write(prog2[k], 8'(8'h20 + k));
      i_host_serial_model.write_reg(`REG_PC, 8'h20);
      i_host_serial_model.pulse_run();
      for (int n = 0; n < 200 && o_porta[2] !== 1'b1; n++)
      begin
         @(posedge i_core_clk);
         #1;
      end
      cnt = 0;
      while (o_porta[2] === 1'b1 && cnt < 200)
      begin
         @(posedge i_core_clk);
         #1;
         cnt++;
      end
      check(8'(cnt), 8'(3 * TICKS));
      for (int n = 0; n < 200 && o_porta[0] !== 1'b1; n++)
      begin
         @(posedge i_core_clk);
         #1;
      end
      check(8'(o_porta[0]), 8'h01);
      i_host_serial_model.pulse_step();
      repeat (4) @(posedge i_core_clk);
      stk.push_back(8'h42);
      rd_check(`REG_STACK, 8'h42);
      rd_check(`REG_PC, 8'h24);
      rd_check(`REG_SP, 8'(stk.size()));
      $display("test delay sleep step done");
      @(posedge i_core_clk);
      i_reset <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_reset <= 1'b0;
      stk.delete();
      rd_check(`REG_PC, `PTR_RESET);
      push(8'h10);
      execute_in_place_op(`OP_RDPROG);
      rd_check(`REG_STACK, `PROG_RESET);
      rd_check(`REG_SP, 8'h01);
      $display("test second reset done");
      report_and_stop();
   end

   initial
   begin
      repeat (30000) @(posedge i_core_clk);
      err_count++;
      report_and_stop();
   end
endmodule // stack_language_cpu_test
